// ===== rtl/rf_sched_pkg.sv
// Shared constants and types of the RF frame interval scheduler.
// Assumes a 32-bit AXI4-Lite master and a 200 MHz system clock.
package rf_sched_pkg;
    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] ADDR_SEQ  = 8'h00;
    localparam logic [7:0] ADDR_BASE = 8'h04;
    localparam logic [7:0] ADDR_SEED = 8'h08;
    localparam logic [7:0] ADDR_FNT  = 8'h0C;
    localparam logic [7:0] ADDR_CTRL = 8'h10;
    localparam logic [7:0] ADDR_STAT = 8'h14;
    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int SEQ_DATA    = 7;
    localparam int SEQ_INTERFRAME_POWER_DOWN    = 6;
    localparam int SEQ_INITIAL_SPACE_ENABLE    = 5;
    localparam int SEQ_INTERRUPT_DELAY_SELECT    = 4;
    localparam int SEED_VCO_HIGH_POWER  = 7;
    localparam int CTRL_SEND   = 7;
    localparam int CTRL_ACK    = 4;
    localparam int CTRL_IEN    = 3;
    localparam int CTRL_DIRECT = 1;
    localparam int CTRL_MRST   = 0;
    // ****************************************************************
    // Reset values, responses and timing
    // ****************************************************************
    localparam logic [7:0]  RST_BYTE    = 8'h00;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    localparam int          CLK_PERIOD_PS   = 5000;
    localparam int          TICK_NS         = 1000000;
    localparam int          TICK_CYCLES_DEF = TICK_NS * 1000 / CLK_PERIOD_PS;
    localparam int          REM_W           = 12;
    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE, ST_GAP, ST_START, ST_FRAME, ST_DONE
    } seq_state_t;
    typedef struct packed {
        logic [7:0] seq;
        logic [7:0] base;
        logic [7:0] seed;
        logic [5:0] fnt;
    } cfg_t;
    typedef struct packed {
        logic send;
        logic ien;
        logic direct;
    } ctrl_t;
endpackage

// ===== rtl/rf_frame_interval_scheduler.sv
// Frame sequencing and interframe timing of one RF datagram.
// Assumes an AXI4-Lite master, a frame engine giving frame_done pulses,
// and error and low-voltage flags held by neighbouring logic.
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
module rf_frame_interval_scheduler
#(
    parameter int unsigned TICK_CYCLES = rf_sched_pkg::TICK_CYCLES_DEF
) (
    // Clock, reset, enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Frame engine
    output logic             frame_start,
    input  wire logic        frame_done,
    // Neighbouring flags
    input  wire logic        tx_error_flag,
    input  wire logic        low_voltage_flag,
    // Analog controls and interrupt
    output logic             crystal_oscillator_enable,
    output logic             vco_high_power,
    output logic             pa_out,
    output logic             rf_irq
);
    import rf_sched_pkg::*;
    if (TICK_CYCLES < 2) begin : g_tick_check
        $error("TICK_CYCLES must be at least 2");
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [6:0] lfsr_step(input logic [6:0] l);
        lfsr_step = {l[5:0], l[6] ^ l[5]};
    endfunction
    function automatic logic [REM_W-1:0] gap_len(input logic [7:0] b,
        input logic [5:0] f, input logic [4:0] n, input logic [6:0] r);
        logic [REM_W-1:0] fn;
        fn = REM_W'(f) * REM_W'(n);
        if (r == 7'h00) begin
            gap_len = (REM_W'(b) > fn) ? REM_W'(b) : fn;
        end else begin
            gap_len = REM_W'(b) + fn + REM_W'(r);
        end
    endfunction

    // ****************************************************************
    // AXI4-Lite slave
    // ****************************************************************
    cfg_t              cfg;
    ctrl_t             ctrl;
    seq_state_t        state;
    logic              flag;
    logic              mrst;
    logic              srst;
    logic [6:0]        lfsr;
    logic [4:0]        frames_sent;
    logic [REM_W-1:0]  remain;
    logic              last_gap;
    logic              send_q;
    logic              aw_got;
    logic              w_got;
    logic [7:0]        aw_addr;
    logic [31:0]       w_data;
    logic              w_lane0;
    logic              wr_go;
    logic [31:0]       rd_val;
    logic              rd_ok;
    logic              wr_ok;

    assign srst = !aresetn || mrst;
    assign s_axi_awready = ce && !aw_got && !s_axi_bvalid;
    assign s_axi_wready  = ce && !w_got && !s_axi_bvalid;
    assign s_axi_arready = ce && !s_axi_rvalid;
    assign wr_go = aw_got && w_got && !s_axi_bvalid;
    assign wr_ok = aw_addr inside {ADDR_SEQ, ADDR_BASE, ADDR_SEED,
                                   ADDR_FNT, ADDR_CTRL, ADDR_STAT};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got  <= 1'b0;
            w_got   <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_lane0 <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got  <= 1'b1;
                aw_addr <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got   <= 1'b1;
                w_data  <= s_axi_wdata;
                w_lane0 <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_got <= 1'b0;
                w_got  <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    function automatic logic wr_hit(input logic [7:0] a);
        wr_hit = wr_go && w_lane0 && aw_addr == a;
    endfunction
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_ok  = 1'b1;
        unique case ({s_axi_araddr[7:2], 2'h0})
            ADDR_SEQ:  rd_val[7:0] = cfg.seq;
            ADDR_BASE: rd_val[7:0] = cfg.base;
            ADDR_SEED: rd_val[7:0] = cfg.seed;
            ADDR_FNT:  rd_val[5:0] = cfg.fnt;
            ADDR_CTRL: rd_val[7:0] = {ctrl.send, 3'h0, ctrl.ien, 1'b0,
                                      ctrl.direct, 1'b0};
            ADDR_STAT: rd_val = {8'h00, 1'b0, lfsr, 3'h0, frames_sent,
                                 3'h0, state != ST_IDLE,
                                 crystal_oscillator_enable,
                                 low_voltage_flag, tx_error_flag, flag};
            default:   rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_val;
                s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Configuration registers and module reset
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mrst <= 1'b0;
        end else if (ce) begin
            mrst <= wr_hit(ADDR_CTRL) && w_data[CTRL_MRST];
        end
    end
    always_ff @(posedge aclk) begin
        if (srst) begin
            cfg <= '0;
        end else if (ce) begin
            if (wr_hit(ADDR_SEQ)) begin
                cfg.seq <= w_data[7:0];
            end
            if (wr_hit(ADDR_BASE)) begin
                cfg.base <= w_data[7:0];
            end
            if (wr_hit(ADDR_SEED)) begin
                cfg.seed <= w_data[7:0];
            end
            if (wr_hit(ADDR_FNT)) begin
                cfg.fnt <= w_data[5:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (srst) begin
            ctrl <= '0;
        end else if (ce) begin
            if (wr_hit(ADDR_CTRL)) begin
                ctrl.send   <= w_data[CTRL_SEND];
                ctrl.ien    <= w_data[CTRL_IEN];
                ctrl.direct <= w_data[CTRL_DIRECT];
            end else if (state == ST_DONE) begin
                ctrl.send <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Datagram sequencer
    // ****************************************************************
    logic                            start;
    logic                            tick;
    logic                            last_frame;
    logic [$clog2(TICK_CYCLES)-1:0]  tick_cnt;
    logic [4:0]                      next_sent;
    logic                            next_osc;

    assign start      = ctrl.send && !send_q && state == ST_IDLE;
    assign tick       = tick_cnt == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1);
    assign last_frame = frames_sent == {1'b0, cfg.seq[3:0]};
    assign next_sent  = frames_sent + 5'h01;

    always_ff @(posedge aclk) begin
        if (srst) begin
            send_q <= 1'b0;
        end else if (ce) begin
            send_q <= ctrl.send;
        end
    end
    always_ff @(posedge aclk) begin
        if (srst || state != ST_GAP) begin
            tick_cnt <= '0;
        end else if (ce) begin
            tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (srst) begin
            state       <= ST_IDLE;
            frames_sent <= 5'h00;
            remain      <= '0;
            last_gap    <= 1'b0;
            lfsr        <= 7'h00;
        end else if (ce) begin
            if (!ctrl.send && state != ST_DONE) begin
                state <= ST_IDLE;
            end else begin
                unique case (state)
                    ST_IDLE: if (start) begin
                        frames_sent <= 5'h00;
                        last_gap    <= 1'b0;
                        if (cfg.seq[SEQ_INITIAL_SPACE_ENABLE]) begin
                            state  <= ST_GAP;
                            remain <= gap_len(cfg.base, cfg.fnt, 5'h00,
                                              cfg.seed[6:0]);
                            lfsr   <= lfsr_step(cfg.seed[6:0]);
                        end else begin
                            state <= ST_START;
                            lfsr  <= cfg.seed[6:0];
                        end
                    end
                    ST_GAP: if (remain == '0) begin
                        state <= last_gap ? ST_DONE : ST_START;
                    end else if (tick) begin
                        remain <= remain - 1'b1;
                    end
                    ST_START: state <= ST_FRAME;
                    ST_FRAME: if (frame_done) begin
                        frames_sent <= next_sent;
                        if (last_frame && !cfg.seq[SEQ_INTERRUPT_DELAY_SELECT]) begin
                            state <= ST_DONE;
                        end else begin
                            state    <= ST_GAP;
                            last_gap <= last_frame;
                            remain   <= gap_len(cfg.base, cfg.fnt,
                                                next_sent, lfsr);
                            lfsr     <= lfsr_step(lfsr);
                        end
                    end
                    ST_DONE: state <= ST_IDLE;
                endcase
            end
        end
    end

    // ****************************************************************
    // Outputs, completion flag and interrupt
    // ****************************************************************
    always_comb begin
        next_osc = ctrl.send;
        if (cfg.seq[SEQ_INTERFRAME_POWER_DOWN] && state == ST_GAP) begin
            next_osc = ctrl.send && !last_gap && remain <= REM_W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (srst) begin
            crystal_oscillator_enable <= 1'b0;
            vco_high_power <= 1'b0;
            pa_out         <= 1'b0;
            frame_start    <= 1'b0;
        end else if (ce) begin
            crystal_oscillator_enable <= next_osc;
            vco_high_power <= cfg.seed[SEED_VCO_HIGH_POWER];
            pa_out         <= ctrl.direct && cfg.seq[SEQ_DATA];
            frame_start    <= state == ST_START && ctrl.send;
        end
    end

    always_ff @(posedge aclk) begin
        if (srst) begin
            flag   <= 1'b0;
            rf_irq <= 1'b0;
        end else if (ce) begin
            if (state == ST_DONE) begin
                flag <= 1'b1;
            end else if (wr_hit(ADDR_CTRL) && w_data[CTRL_ACK]) begin
                flag <= 1'b0;
            end
            rf_irq <= ctrl.ien && (flag || tx_error_flag
                                   || low_voltage_flag);
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !ce);

    chk_direct_low: assert property (
        !ctrl.direct && !mrst |=> !pa_out)
        else $error("amplifier driven outside direct mode");
    chk_osc_held: assert property (
        ctrl.send && !cfg.seq[SEQ_INTERFRAME_POWER_DOWN] && !mrst
        |=> crystal_oscillator_enable)
        else $error("oscillator off while send set");
    chk_osc_gap_off: assert property (
        state == ST_GAP && cfg.seq[SEQ_INTERFRAME_POWER_DOWN] && remain > REM_W'(1)
        && !mrst |=> !crystal_oscillator_enable)
        else $error("oscillator on in power-down gap");
    chk_osc_restart: assert property (
        state == ST_GAP && ctrl.send && !last_gap && remain == REM_W'(1)
        && !mrst |=> crystal_oscillator_enable)
        else $error("oscillator not restarted before frame");
    chk_init_space: assert property (
        start && !mrst |=> (state == ST_GAP) == $past(cfg.seq[SEQ_INITIAL_SPACE_ENABLE]))
        else $error("initial space handling wrong");
    chk_flag_now: assert property (
        state == ST_FRAME && frame_done && last_frame && ctrl.send
        && !cfg.seq[SEQ_INTERRUPT_DELAY_SELECT] && !mrst && !wr_go
        |=> state == ST_DONE ##1 flag)
        else $error("completion flag not raised after last frame");
    chk_flag_late: assert property (
        state == ST_FRAME && frame_done && last_frame && ctrl.send
        && cfg.seq[SEQ_INTERRUPT_DELAY_SELECT] && !mrst && !wr_go
        |=> state == ST_GAP && last_gap)
        else $error("delayed completion skipped extra interval");
    chk_frame_limit: assert property (
        frame_start |-> frames_sent <= {1'b0, cfg.seq[3:0]})
        else $error("too many frames started");
    chk_mrst_clear: assert property (
        mrst |=> cfg == '0 && !ctrl.send && state == ST_IDLE)
        else $error("module reset left state behind");
    chk_lfsr_load: assert property (
        start && !cfg.seq[SEQ_INITIAL_SPACE_ENABLE] && !mrst |=> lfsr == $past(cfg.seed[6:0]))
        else $error("seed not loaded at send");
    chk_lfsr_zero: assert property (
        lfsr == 7'h00 && !start && !mrst |=> lfsr == 7'h00)
        else $error("zero LFSR left zero state");
    chk_send_clear: assert property (
        state == ST_DONE && !wr_go && !mrst |=> !ctrl.send)
        else $error("send not cleared at end");
    chk_irq_gate: assert property (
        !ctrl.ien |=> !rf_irq)
        else $error("interrupt raised while disabled");
endmodule

// ===== tb/rf_frame_interval_scheduler_tb_top.sv
// Self-checking bench of the RF frame interval scheduler.
// Assumes TICK_CYCLES of 4 and a frame engine played by the bench.
module rf_frame_interval_scheduler_tb_top
    import rf_sched_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // Signals and frame engine
    // ****************************************************************
    localparam int T = 4;
    logic        aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, frame_start, tx_error_flag, low_voltage_flag;
    logic        crystal_oscillator_enable, vco_high_power, pa_out, rf_irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        frame_done = 1'b0;
    logic        clr = 1'b0;
    logic [1:0]  last_bresp = 2'h0;
    int          errors = 0, num_checks = 0, cyc = 0, starts = 0, gap = 0;
    int          dcnt = 0, done_cyc = 0, irq_cyc = 0, first_cyc = 0;
    int          send_cyc = 0, osc_low = 0, osc_bad = 0, low_run = 0;

    rf_frame_interval_scheduler #(.TICK_CYCLES(T)) i_dut (.*);

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // Frame engine answers each start with a done pulse three cycles on
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        frame_done <= (dcnt == 1);
        dcnt <= frame_start ? 3 : (dcnt > 0 ? dcnt - 1 : 0);
        if (dcnt == 1) begin
            done_cyc <= cyc;
            low_run <= 0;
        end else if (!crystal_oscillator_enable) begin
            low_run <= low_run + 1;
        end
        if (frame_start) begin
            starts <= starts + 1;
            gap <= cyc - done_cyc;
            if (starts == 0) first_cyc <= cyc;
            if (starts > 0) osc_low <= osc_low + low_run;
            if (!crystal_oscillator_enable) osc_bad <= osc_bad + 1;
        end
        if (rf_irq && irq_cyc == 0) irq_cyc <= cyc;
        if (clr) begin
            starts <= 0;
            osc_low <= 0;
            osc_bad <= 0;
            irq_cyc <= 0;
        end
    end
    // ****************************************************************
    // Bus and check tasks
    // ****************************************************************
    task automatic results();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic tmo();
        errors++;
        results();
    endtask

    task automatic chk(input string n, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            errors++;
        end
    endtask

    task automatic chkin(input string n, input int lo, hi, v);
        num_checks++;
        if (v < lo || v > hi) begin
            $display("[ERR] %s expected %0d..%0d seen %0d", n, lo, hi, v);
            errors++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int i;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        last_bresp = s_axi_bresp;
        if (i == 100) tmo();
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int i;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        if (i == 100) tmo();
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk($sformatf("reg %h", a), {24'h0, e}, d);
    endtask

    // Programs one datagram, sends it and waits until busy falls
    task automatic run(input logic [7:0] s, b, f, sd);
        logic [31:0] d;
        logic [1:0]  r;
        int i;
        wr(ADDR_SEQ, s);
        wr(ADDR_BASE, b);
        wr(ADDR_FNT, f);
        wr(ADDR_SEED, sd);
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
        send_cyc = cyc;
        wr(ADDR_CTRL, 8'h88);
        for (i = 0; i < 400; i++) begin
            rd(ADDR_STAT, d, r);
            if (d[4] === 1'b0) break;
        end
        if (i == 400) tmo();
    endtask

    task automatic post(input int n, output logic [31:0] d);
        logic [1:0] r;
        chk("frames", 32'(n), 32'(starts));
        rd(ADDR_STAT, d, r);
        chk("flag", 32'h1, 32'(d[0]));
        chk("irq", 32'h1, 32'(rf_irq));
        rc(ADDR_CTRL, 8'h08);
        wr(ADDR_CTRL, 8'h10);
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0]  r;
        rc(ADDR_SEQ, RST_BYTE);
        rc(ADDR_BASE, RST_BYTE);
        rc(ADDR_SEED, RST_BYTE);
        rc(ADDR_FNT, RST_BYTE);
        rd(8'h40, d, r);
        chk("unmapped resp", 32'(RESP_SLVERR), 32'(r));
        wr(8'h40, 8'h55);
        chk("unmapped wr resp", 32'(RESP_SLVERR), 32'(last_bresp));
        wr(ADDR_BASE, 8'hA5);
        chk("wr resp", 32'(RESP_OKAY), 32'(last_bresp));
        rd(ADDR_BASE, d, r);
        chk("rd resp", 32'(RESP_OKAY), 32'(r));
        rc(ADDR_BASE, 8'hA5);
        ce <= 1'b0;
        repeat (3) @(posedge aclk);
        chk("frozen awready", 32'h0, 32'(s_axi_awready));
        chk("frozen arready", 32'h0, 32'(s_axi_arready));
        ce <= 1'b1;
        $display("test reset done");
    endtask

    task automatic t_pins();
        wr(ADDR_SEQ, 8'h80);
        wr(ADDR_CTRL, 8'h0A);
        low_voltage_flag <= 1'b1;
        repeat (2) @(posedge aclk);
        chk("pa_out", 32'h1, 32'(pa_out));
        chk("irq", 32'h1, 32'(rf_irq));
        wr(ADDR_SEQ, 8'h00);
        wr(ADDR_SEED, 8'h80);
        low_voltage_flag <= 1'b0;
        tx_error_flag <= 1'b1;
        repeat (2) @(posedge aclk);
        chk("pa_out", 32'h0, 32'(pa_out));
        chk("vco", 32'h1, 32'(vco_high_power));
        chk("irq", 32'h1, 32'(rf_irq));
        wr(ADDR_CTRL, 8'h02);
        wr(ADDR_SEED, 8'h00);
        repeat (2) @(posedge aclk);
        chk("irq", 32'h0, 32'(rf_irq));
        chk("vco", 32'h0, 32'(vco_high_power));
        tx_error_flag <= 1'b0;
        wr(ADDR_CTRL, 8'h00);
        $display("test pins done");
    endtask

    task automatic t_count();
        logic [31:0] d;
        run(8'h02, 8'h05, 8'h00, 8'h00);
        post(3, d);
        chkin("gap", 5 * T, 5 * T + 8, gap);
        chk("osc low", 32'h0, 32'(osc_low));
        chkin("first", 0, 12, first_cyc - send_cyc);
        chkin("irq lag", 0, 6, irq_cyc - done_cyc);
        chk("lfsr", 32'h0, 32'(d[22:16]));
        $display("test count done");
    endtask

    task automatic t_larger();
        logic [31:0] d;
        run(8'h01, 8'h05, 8'h09, 8'h00);
        post(2, d);
        chkin("gap", 9 * T, 9 * T + 8, gap);
        $display("test larger done");
    endtask

    task automatic t_pdown();
        logic [31:0] d;
        run(8'h41, 8'h05, 8'h00, 8'h00);
        post(2, d);
        chk("osc at start", 32'h0, 32'(osc_bad));
        chkin("osc low", 3 * T, 4 * T + 4, osc_low);
        $display("test power down done");
    endtask

    task automatic t_random();
        logic [31:0] d;
        run(8'h01, 8'h05, 8'h00, 8'h01);
        post(2, d);
        chkin("gap", 6 * T, 7 * T + 8, gap);
        chk("lfsr live", 32'h1, 32'(|d[22:16]));
        $display("test random done");
    endtask

    task automatic t_initial_space_enable_interrupt_delay_select();
        logic [31:0] d;
        run(8'h20, 8'h05, 8'h00, 8'h00);
        post(1, d);
        chkin("first", 5 * T, 5 * T + 14, first_cyc - send_cyc);
        run(8'h10, 8'h05, 8'h00, 8'h00);
        post(1, d);
        chkin("irq lag", 5 * T, 5 * T + 10, irq_cyc - done_cyc);
        $display("test delays done");
    endtask

    task automatic t_abort();
        logic [31:0] d;
        logic [1:0]  r;
        int i;
        wr(ADDR_SEQ, 8'h05);
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
        wr(ADDR_CTRL, 8'h88);
        for (i = 0; i < 100 && starts == 0; i++) @(posedge aclk);
        if (starts == 0) tmo();
        repeat (5) @(posedge aclk);
        wr(ADDR_CTRL, 8'h08);
        repeat (10 * T) @(posedge aclk);
        chk("frames", 32'h1, 32'(starts));
        rd(ADDR_STAT, d, r);
        chk("stat", 32'h0, 32'(d[4:0]));
        $display("test abort done");
    endtask

    task automatic t_mrst();
        wr(ADDR_SEQ, 8'h7F);
        wr(ADDR_BASE, 8'h10);
        wr(ADDR_SEED, 8'hFF);
        wr(ADDR_CTRL, 8'h01);
        repeat (3) @(posedge aclk);
        rc(ADDR_SEQ, RST_BYTE);
        rc(ADDR_BASE, RST_BYTE);
        rc(ADDR_SEED, RST_BYTE);
        $display("test soft reset done");
    endtask

    initial begin
        aresetn = 1'b0;
        ce = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {tx_error_flag, low_voltage_flag} = 2'h0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_pins();
        t_count();
        t_larger();
        t_pdown();
        t_random();
        t_initial_space_enable_interrupt_delay_select();
        t_abort();
        t_mrst();
        results();
    end
endmodule
